// ---- logic/pqu_booth_array.sv ----
/*
  Radix-4 Booth recoded 33x17 signed array; one pass per cycle.
  Assumes the caller sign- or zero-extends both operands.
*/
`timescale 1ns/1ns
module pqu_booth_array
(
  // operands and product
  pqu_mul_if.array mul
);

  logic [18:0] bx;
  logic [49:0] sa;
  logic [49:0] pp;
  logic [49:0] acc;
  logic [2:0] trip;

  always_comb
  begin
    // a zero below bit 0 keeps every digit window inside the vector
    bx = {mul.mplier[16], mul.mplier, 1'b0};
    sa = {{17{mul.mcand[32]}}, mul.mcand};
    acc = 50'h0;
    pp = 50'h0;
    trip = 3'h0;
    // nine recoded digits cover the 17-bit multiplier
    for (int i = 0; i < 9; i++)
    begin
      trip = bx[2*i+2 -: 3];
      unique case (trip)
        3'b001, 3'b010: pp = sa;
        3'b011: pp = sa << 1;
        3'b100: pp = 50'h0 - (sa << 1);
        3'b101, 3'b110: pp = 50'h0 - sa;
        default: pp = 50'h0;
      endcase
      acc = acc + (pp << (2 * i));
    end
    mul.product = acc;
  end

endmodule

// ---- logic/pqu_mul_if.sv ----
/*
  Link between the unit's control and its Booth multiplier array.
  Assumes the array is purely combinational.
*/
`timescale 1ns/1ns
interface pqu_mul_if;
  logic [32:0] mcand;
  logic [16:0] mplier;
  logic [49:0] product;
  modport array (input mcand, input mplier, output product);
  modport user (output mcand, output mplier, input product);
endinterface

// ---- logic/pqu_pkg.sv ----
/*
  Types of the product/quotient unit: operations, array pass states and the
  packed state record. Assumes nothing of its surroundings.
*/
package pqu_pkg;

  typedef enum logic [6:0] {
    pair_product_op        = 7'h01,
    accumulate_add_op      = 7'h02,
    accumulate_subtract_op = 7'h04,
    reg_product_op         = 7'h08,
    pair_quotient_op       = 7'h10,
    move_from_upper        = 7'h20,
    move_from_lower        = 7'h40
  } pqu_op_e;

  typedef enum logic [3:0] {
    pass_idle   = 4'h1,
    pass_single = 4'h2,
    pass_first  = 4'h4,
    pass_second = 4'h8
  } pqu_pass_e;

  typedef struct packed {
    pqu_pass_e stage;
    pqu_op_e s_op;
    logic s_sgn;
    logic [32:0] s_a;
    logic [31:0] s_rt;
    logic [4:0] s_tag;
    logic [49:0] s_part;
    logic done_valid;
    logic [4:0] done_tag;
    logic [31:0] done_data;
    logic out_valid;
    logic [4:0] out_tag;
    logic [31:0] out_data;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [5:0] div_cnt;
    logic [5:0] div_iter;
    logic [31:0] div_rem;
    logic [31:0] div_quo;
    logic [31:0] div_dsr;
    logic div_neg_q;
    logic div_neg_r;
  } pqu_state_s;

endpackage

// ---- logic/pqu_regs.svh ----
/*
  Constants of the product/quotient unit: operand widths, early-in skip counts
  and issue timing in pipeline clocks. Assumes inclusion by bare name only.

*/
`ifndef PQU_REGS_SVH
`define PQU_REGS_SVH

`define PQU_CLK_PERIOD_NS 40
`define PQU_SHORT_BITS 16
`define PQU_DIV_W8 8
`define PQU_DIV_W16 16
`define PQU_DIV_W24 24
`define PQU_DIV_SKIP_8 6'd23
`define PQU_DIV_SKIP_16 6'd15
`define PQU_DIV_SKIP_24 6'd7
`define PQU_DIV_SKIP_32 6'd0
`define PQU_DIV_BITS 6'd32
`define PQU_DIV_REP_8 6'd11
`define PQU_DIV_REP_16 6'd18
`define PQU_DIV_REP_24 6'd25
`define PQU_DIV_REP_32 6'd32
`define PQU_ACC_RESET 32'h0000_0000

`endif

// ---- logic/pqu_top.sv ----
/*
  Product/quotient unit: multiply pipeline around a 33x17 Booth array, an
  early-in restoring divider and the accumulator pair.
  Assumes the integer pipeline holds issue_valid and operands while
  issue_stall is high, and reads the accumulator pair only through the move operations.
*/
`timescale 1ns/1ns
`include "pqu_regs.svh"
module pqu_top
  import pqu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // issue from the integer pipeline
  input wire logic issue_valid,
  input wire pqu_op_e issue_op,
  input wire logic issue_signed,
  input wire logic [31:0] dividend_operand,
  input wire logic [31:0] second_operand,
  input wire logic [4:0] issue_tag,
  output logic issue_stall,
  // general register write-back
  output logic gpr_wr_valid,
  output logic [4:0] gpr_wr_tag,
  output logic [31:0] gpr_wr_data,
  // accumulator pair and status
  output logic [31:0] upper_accumulator,
  output logic [31:0] lower_accumulator,
  output logic divide_busy
);

  pqu_state_s st;
  pqu_state_s next_st;
  pqu_mul_if mul ();

  logic fin;
  logic uses_array;
  logic is_mul;
  logic accept;
  logic [63:0] p_ext;
  logic [63:0] prod;
  logic [63:0] pair;
  logic [32:0] trial;
  logic [31:0] mag;
  logic [5:0] skip;
  logic [5:0] rep;

  pqu_booth_array u_array
  (
    .mul(mul)
  );

  // true when v is a sign (or zero) extension of its low w bits
  function automatic logic pqu_fits(input logic [31:0] v, input logic sgn, input int w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      if (sgn && (i >= w - 1) && (v[i] != v[31]))
        ok = 1'b0;
      if (!sgn && (i >= w) && v[i])
        ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic [31:0] pqu_neg(input logic en, input logic [31:0] v);
    return en ? 32'h0 - v : v;
  endfunction

  always_comb
  begin
    next_st = st;
    pair = {st.upper, st.lower};
    prod = 64'h0;
    p_ext = 64'h0;
    trial = 33'h0;
    mag = 32'h0;
    skip = `PQU_DIV_SKIP_32;
    rep = `PQU_DIV_REP_32;
    fin = 1'b0;
    next_st.done_valid = 1'b0;
    next_st.out_valid = st.done_valid;
    next_st.out_tag = st.done_tag;
    next_st.out_data = st.done_data;

    // only the second operand picks the pass, the first is fed whole
    mul.mcand = st.s_a;
    unique case (st.stage)
      pass_first: mul.mplier = {1'b0, st.s_rt[15:0]};
      pass_second: mul.mplier = {st.s_sgn & st.s_rt[31], st.s_rt[31:16]};
      pass_idle, pass_single: mul.mplier = {st.s_sgn & st.s_rt[15], st.s_rt[15:0]};
      default: mul.mplier = 17'h0;
    endcase
    p_ext = {{14{mul.product[49]}}, mul.product};

    // the array stage moves every cycle, whatever the issue side does
    unique case (st.stage)
      pass_single:
      begin
        fin = 1'b1;
        prod = p_ext;
        next_st.stage = pass_idle;
      end
      pass_first:
      begin
        next_st.s_part = mul.product;
        next_st.stage = pass_second;
      end
      pass_second:
      begin
        fin = 1'b1;
        prod = (p_ext << 16) + {{14{st.s_part[49]}}, st.s_part};
        next_st.stage = pass_idle;
      end
      default: next_st.stage = pass_idle;
    endcase

    if (fin)
    begin
      unique case (st.s_op)
        pair_product_op: {next_st.upper, next_st.lower} = prod;
        accumulate_add_op: {next_st.upper, next_st.lower} = pair + prod;
        accumulate_subtract_op: {next_st.upper, next_st.lower} = pair - prod;
        reg_product_op:
        begin
          // extra stage through done/out gives latency 2 and 3
          next_st.done_valid = 1'b1;
          next_st.done_data = prod[31:0];
        end
        move_from_upper:
        begin
          next_st.done_valid = 1'b1;
          next_st.done_data = st.upper;
        end
        move_from_lower:
        begin
          next_st.done_valid = 1'b1;
          next_st.done_data = st.lower;
        end
        default: next_st.done_valid = 1'b0;
      endcase
      next_st.done_tag = st.s_tag;
    end

    // divider: one quotient bit per edge while div_iter is nonzero, result on the last counted edge
    if (st.div_cnt != 6'd0)
    begin
      if (st.div_iter != 6'd0)
      begin
        trial = {st.div_rem, st.div_quo[31]} - {1'b0, st.div_dsr};
        if (!trial[32])
          next_st.div_rem = trial[31:0];
        else
          next_st.div_rem = {st.div_rem[30:0], st.div_quo[31]};
        next_st.div_quo = {st.div_quo[30:0], ~trial[32]};
        next_st.div_iter = st.div_iter - 6'd1;
      end
      next_st.div_cnt = st.div_cnt - 6'd1;
      if (st.div_cnt == 6'd1)
      begin
        next_st.lower = pqu_neg(st.div_neg_q, next_st.div_quo);
        next_st.upper = pqu_neg(st.div_neg_r, next_st.div_rem);
      end
    end

    is_mul = (issue_op == pair_product_op) || (issue_op == accumulate_add_op) ||
      (issue_op == accumulate_subtract_op) || (issue_op == reg_product_op);
    uses_array = is_mul || (issue_op == move_from_upper) || (issue_op == move_from_lower);
    // a running divide holds off everything until its final edge
    // a full multiply in its first pass holds off the next array user
    issue_stall = issue_valid && ((st.div_cnt > 6'd1) || (uses_array && (st.stage == pass_first)));
    accept = issue_valid && !issue_stall;

    if (accept && uses_array)
    begin
      next_st.s_op = issue_op;
      next_st.s_sgn = issue_signed;
      next_st.s_a = {issue_signed & dividend_operand[31], dividend_operand};
      next_st.s_rt = second_operand;
      next_st.s_tag = issue_tag;
      // size taken from the value itself, not from the instruction
      if (is_mul && !pqu_fits(second_operand, issue_signed, `PQU_SHORT_BITS))
        next_st.stage = pass_first;
      else
        next_st.stage = pass_single;
    end

    if (accept && (issue_op == pair_quotient_op))
    begin
      mag = pqu_neg(issue_signed & dividend_operand[31], dividend_operand);
      if (pqu_fits(dividend_operand, issue_signed, `PQU_DIV_W8))
      begin
        skip = `PQU_DIV_SKIP_8;
        rep = `PQU_DIV_REP_8;
      end
      else if (pqu_fits(dividend_operand, issue_signed, `PQU_DIV_W16))
      begin
        skip = `PQU_DIV_SKIP_16;
        rep = `PQU_DIV_REP_16;
      end
      else if (pqu_fits(dividend_operand, issue_signed, `PQU_DIV_W24))
      begin
        skip = `PQU_DIV_SKIP_24;
        rep = `PQU_DIV_REP_24;
      end
      // skipped leading bits are shifted out before the first iteration
      next_st.div_quo = mag << skip;
      next_st.div_rem = 32'h0;
      next_st.div_iter = `PQU_DIV_BITS - skip;
      next_st.div_cnt = rep;
      next_st.div_dsr = pqu_neg(issue_signed & second_operand[31], second_operand);
      next_st.div_neg_q = issue_signed & (dividend_operand[31] ^ second_operand[31]);
      next_st.div_neg_r = issue_signed & dividend_operand[31];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.stage <= pass_idle;
      st.s_op <= pair_product_op;
      st.upper <= `PQU_ACC_RESET;
      st.lower <= `PQU_ACC_RESET;
    end
    else
      st <= next_st;
  end

  assign gpr_wr_valid = st.out_valid;
  assign gpr_wr_tag = st.out_tag;
  assign gpr_wr_data = st.out_data;
  assign upper_accumulator = st.upper;
  assign lower_accumulator = st.lower;
  assign divide_busy = (st.div_cnt != 6'd0);

endmodule

// ---- verification/pqu_int_pipe.sv ----
/*
  Stand-in for the integer pipeline: issues one unit op per call.
  Assumes tasks are called just at a rising clock edge.
*/
`timescale 1ns/1ns
module pqu_int_pipe
  import pqu_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // issue port
  input wire logic issue_stall,
  output logic issue_valid,
  output pqu_op_e issue_op,
  output logic issue_signed,
  output logic [31:0] dividend_operand,
  output logic [31:0] second_operand,
  output logic [4:0] issue_tag
);
  logic st;
  initial
  begin
    issue_valid = 1'b0;
    issue_op = move_from_lower;
    issue_signed = 1'b0;
    dividend_operand = 32'h0;
    second_operand = 32'h0;
    issue_tag = 5'h0;
  end
  task automatic issue(input pqu_op_e op, input logic s, input logic [31:0] a,
    input logic [31:0] b, input logic [4:0] t);
    #1;
    issue_valid = 1'b1;
    issue_op = op;
    issue_signed = s;
    dividend_operand = a;
    second_operand = b;
    issue_tag = t;
    // hold the whole request until an edge takes it
    do
    begin
      @(negedge ref_clk);
      st = issue_stall;
      @(posedge ref_clk);
    end
    while (st);
  endtask
  task automatic idle;
    #1;
    issue_valid = 1'b0;
    // released operands must not look like the last request
    dividend_operand = ~dividend_operand;
    second_operand = ~second_operand;
  endtask
endmodule

// ---- verification/pqu_monitor.sv ----
/*
  Checker for pqu_top: issue stalls, product timing, divide length.
  Assumes it is bound to pqu_top and sees only its ports.
*/
`timescale 1ns/1ns
module pqu_monitor
  import pqu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // issue
  input wire logic issue_valid,
  input wire pqu_op_e issue_op,
  input wire logic issue_signed,
  input wire logic [31:0] dividend_operand,
  input wire logic [31:0] second_operand,
  input wire logic issue_stall,
  // results
  input wire logic gpr_wr_valid,
  input wire logic [31:0] upper_accumulator,
  input wire logic [31:0] lower_accumulator,
  input wire logic divide_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire logic taken = issue_valid && !issue_stall;
  wire logic is_mul = issue_op inside {pair_product_op, accumulate_add_op,
    accumulate_subtract_op, reg_product_op};
  wire logic is_arr = is_mul || issue_op inside {move_from_upper, move_from_lower};
  wire logic [16:0] top = second_operand[31:15];
  // short second operand: one pass only
  wire logic sh = issue_signed ? (&top || ~|top) : ~|top[16:1];
  wire logic [63:0] ea = {{32{issue_signed & dividend_operand[31]}}, dividend_operand};
  wire logic [63:0] eb = {{32{issue_signed & second_operand[31]}}, second_operand};
  wire logic [63:0] prod = ea * eb;
  wire logic [63:0] acc = {upper_accumulator, lower_accumulator};

  a_stall_needs_request: assert property (issue_stall |-> issue_valid)
    else $error("stall without request");
  a_short_product: assert property (taken && issue_op == pair_product_op && sh
    |-> ##2 acc == $past(prod, 2)) else $error("short product wrong");
  a_full_product: assert property (taken && issue_op == pair_product_op && !sh
    |-> ##3 acc == $past(prod, 3)) else $error("full product wrong");
  a_full_interlock: assert property (taken && is_mul && !sh ##1 issue_valid && is_arr
    |-> issue_stall) else $error("back to back full not stalled");
  a_short_repeat: assert property (taken && is_mul && sh ##1 issue_valid && is_arr
    && !divide_busy |-> !issue_stall) else $error("short multiply stalled");
  a_reg_latency: assert property (taken && issue_op == reg_product_op && sh
    |-> ##[2:3] gpr_wr_valid) else $error("register product late");
  a_reg_full_latency: assert property (taken && issue_op == reg_product_op && !sh
    |-> ##[3:4] gpr_wr_valid) else $error("full register product late");
  a_divide_minimum: assert property ($rose(divide_busy) |-> divide_busy[*8])
    else $error("divide too short");
  a_divide_bound: assert property ($rose(divide_busy) |-> ##[10:32] !divide_busy)
    else $error("divide too long");
  a_divide_stall: assert property (divide_busy && taken && issue_op != pair_quotient_op
    |=> !divide_busy) else $error("op taken mid divide");

  c_full_stall: cover property (taken && !sh && is_mul ##1 issue_stall);
  c_divide: cover property ($fell(divide_busy));
  c_reg_write: cover property (gpr_wr_valid);
endmodule

bind pqu_top pqu_monitor i_mon (.ref_clk, .reset, .issue_valid, .issue_op, .issue_signed,
  .dividend_operand, .second_operand, .issue_stall, .gpr_wr_valid, .upper_accumulator,
  .lower_accumulator, .divide_busy);

// ---- verification/testbench.sv ----
/*
  Self-checking bench for pqu_top: table of accumulator ops, then
  register multiply, moves, back-to-back issue and divide stall.
*/
`timescale 1ns/1ns
module testbench
  import pqu_pkg::*;
;
  typedef struct packed {pqu_op_e op; logic s; logic [31:0] a; logic [31:0] b;
    logic [5:0] n;} pqu_row_s;
  logic ref_clk, reset, issue_valid, issue_signed, issue_stall, gpr_wr_valid, divide_busy;
  pqu_op_e issue_op;
  logic [31:0] dividend_operand, second_operand, gpr_wr_data;
  logic [31:0] upper_accumulator, lower_accumulator;
  logic [4:0] issue_tag, gpr_wr_tag;
  logic [63:0] acc_exp;
  logic [36:0] got[$];
  int err_total, compares, n;
  time t0;
  pqu_row_s rows[12] = '{
    '{pair_product_op, 1, 32'hffff_fffd, 32'h0000_7fff, 0},
    '{pair_product_op, 0, 32'hffff_ffff, 32'hffff_ffff, 0},
    '{pair_product_op, 1, 32'h8000_0000, 32'h8000_0000, 0},
    '{accumulate_add_op, 1, 32'h1234_5678, 32'hffff_8000, 0},
    '{accumulate_subtract_op, 0, 32'h3, 32'h0001_0000, 0},
    '{pair_quotient_op, 1, 32'hffff_ff80, 32'h7, 11},
    '{pair_quotient_op, 0, 32'hff, 32'h3, 11},
    '{pair_quotient_op, 0, 32'h100, 32'h3, 18},
    '{pair_quotient_op, 1, 32'hffff_8000, 32'hffff_fffd, 18},
    '{pair_quotient_op, 0, 32'h00ff_ffff, 32'h5, 25},
    '{pair_quotient_op, 1, 32'h8000_0001, 32'h9, 32},
    '{pair_quotient_op, 0, 32'hffff_ffff, 32'h10, 32}};

  pqu_top i_dut (.ref_clk, .reset, .issue_valid, .issue_op, .issue_signed, .dividend_operand,
    .second_operand, .issue_tag, .issue_stall, .gpr_wr_valid, .gpr_wr_tag, .gpr_wr_data,
    .upper_accumulator, .lower_accumulator, .divide_busy);
  pqu_int_pipe i_pipe (.ref_clk, .issue_stall, .issue_valid, .issue_op, .issue_signed,
    .dividend_operand, .second_operand, .issue_tag);

  function automatic logic [63:0] model(input pqu_row_s r, input logic [63:0] acc);
    logic [63:0] p;
    logic [31:0] q, m;
    p = {{32{r.s & r.a[31]}}, r.a} * {{32{r.s & r.b[31]}}, r.b};
    q = r.a / r.b;
    m = r.a % r.b;
    if (r.s)
    begin
      q = $signed(r.a) / $signed(r.b);
      m = $signed(r.a) % $signed(r.b);
    end
    case (r.op)
      accumulate_add_op: return acc + p;
      accumulate_subtract_op: return acc - p;
      pair_quotient_op: return {m, q};
      default: return p;
    endcase
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk)
    if (gpr_wr_valid === 1'b1)
      got.push_back({gpr_wr_tag, gpr_wr_data});
  initial
  begin
    #(40 * 3000);
    err_total++;
    results();
  end
  initial
  begin
    err_total = 0;
    compares = 0;
    acc_exp = 64'h0;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1 reset = 1'b0;
    @(negedge ref_clk);
    check({upper_accumulator, lower_accumulator}, 64'h0);
    check({61'h0, gpr_wr_valid, divide_busy, issue_stall}, 64'h0);
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      i_pipe.issue(rows[i].op, rows[i].s, rows[i].a, rows[i].b, 5'h0);
      acc_exp = model(rows[i], acc_exp);
      i_pipe.idle();
      n = 0;
      @(negedge ref_clk);
      while (divide_busy === 1'b1 && n < 40)
      begin
        n++;
        @(negedge ref_clk);
      end
      check(64'(n), 64'(rows[i].n));
      repeat (3) @(posedge ref_clk);
      check({upper_accumulator, lower_accumulator}, acc_exp);
    end
    // full product, register product, both moves, full register product, back to back
    got.delete();
    i_pipe.issue(pair_product_op, 0, 32'h0001_0000, 32'h0003_0000, 5'h0);
    i_pipe.issue(reg_product_op, 1, 32'h5, 32'hffff_fff9, 5'h9);
    i_pipe.issue(move_from_upper, 0, 32'h0, 32'h0, 5'h3);
    i_pipe.issue(move_from_lower, 0, 32'h0, 32'h0, 5'h4);
    i_pipe.issue(reg_product_op, 0, 32'h3, 32'h0001_0001, 5'h6);
    i_pipe.idle();
    repeat (6) @(posedge ref_clk);
    check(64'(got.size()), 64'd4);
    check(64'(got[3]), {27'h0, 5'h6, 32'h0003_0003});
    check(64'(got[0]), {27'h0, 5'h9, 32'hffff_ffdd});
    check(64'(got[1]), {27'h0, 5'h3, 32'h0000_0003});
    check(64'(got[2]), {27'h0, 5'h4, 32'h0});
    // three short products on consecutive edges
    t0 = $time;
    i_pipe.issue(pair_product_op, 1, 32'h7, 32'h7, 5'h0);
    i_pipe.issue(accumulate_add_op, 1, 32'h7, 32'h7, 5'h0);
    i_pipe.issue(accumulate_subtract_op, 1, 32'h2, 32'h7, 5'h0);
    check(64'(($time - t0) / 40), 64'd3);
    i_pipe.idle();
    repeat (3) @(posedge ref_clk);
    check({upper_accumulator, lower_accumulator}, 64'd84);
    // a multiply offered right behind a divide waits for it
    i_pipe.issue(pair_quotient_op, 0, 32'h100, 32'h3, 5'h0);
    t0 = $time;
    i_pipe.issue(pair_product_op, 0, 32'h2, 32'h3, 5'h0);
    check(64'(($time - t0) / 40), 64'd18);
    i_pipe.idle();
    repeat (3) @(posedge ref_clk);
    check({upper_accumulator, lower_accumulator}, 64'd6);
    // reset in the middle of a long divide drops it and clears the pair
    i_pipe.issue(pair_quotient_op, 0, 32'hffff_ffff, 32'h7, 5'h0);
    i_pipe.idle();
    repeat (4) @(posedge ref_clk);
    #1 reset = 1'b1;
    @(posedge ref_clk);
    #1 reset = 1'b0;
    @(negedge ref_clk);
    check({upper_accumulator, lower_accumulator}, 64'h0);
    check({61'h0, gpr_wr_valid, divide_busy, issue_stall}, 64'h0);
    results();
  end
endmodule
